// ==== src/pulse_gear_consts.vh ====
`ifndef PULSE_GEAR_CONSTS_VH
`define PULSE_GEAR_CONSTS_VH

// register offsets on the parameter port
`define OFS_GEAR_NUMERATOR 16'h1910
`define OFS_GEAR_DENOMINATOR 16'h1920
`define OFS_PULSE_FORMAT_SELECT 16'h1930
`define OFS_RAW_PULSE_COUNT 16'h1940
`define OFS_GEARED_PULSE_COUNT 16'h1950
`define OFS_PULSE_FILTER_SETTING 16'h1960
`define OFS_RAW_PULSE_RATE 16'h19c0
`define OFS_GEARED_PULSE_RATE 16'h19d0
`define OFS_CONFIG_STORE_COMMAND 16'h2910
`define OFS_MOTOR_PARAM_STORE_COMMAND 16'h2930

// reset values
`define RST_GEAR_NUMERATOR 16'h03e8
`define RST_GEAR_DENOMINATOR 16'h03e8
`define RST_PULSE_FORMAT_SELECT 8'h01
`define RST_PULSE_FILTER_SETTING 16'h0003

// pulse formats
`define FMT_DOUBLE_PULSE 8'h00
`define FMT_PULSE_DIR 8'h01
`define FMT_QUADRATURE 8'h02
`define FMT_DIFF_DOUBLE_PULSE 8'h0a
`define FMT_DIFF_PULSE_DIR 8'h0b
`define FMT_DIFF_QUADRATURE 8'h0c

// storage command values
`define CMD_STORE_ALL 8'h01
`define CMD_INIT_ALL 8'h0a

// timing: one rate window is one millisecond
`define RATE_WINDOW_NS 1000000
`define CLK_PERIOD_NS 8

`endif

// ==== src/pulse_command_input_gear.v ====
`timescale 1ns/1ns

`include "pulse_gear_consts.vh"

// What this block does
// - format 0 double pulse, 1 pulse plus direction, 2 quadrature, single-ended inputs.
// - formats 10, 11, 12 are the same three formats on differential 422 inputs.
// - 8-bit format selector, default 1; takes effect only after store and restart.
// - gear numerator is signed 16-bit, default 1000.
// - gear denominator is unsigned 16-bit, default 1000, unity ratio by default.
// - signed 32-bit raw pulse count, starts at zero, host may overwrite.
// - signed 32-bit geared pulse count, starts at zero, host may overwrite.
// - raw pulse rate, signed 16-bit read-only, pulses per millisecond, starts zero.
// - geared pulse rate, signed 16-bit read-only, pulses per millisecond.
// - store command 1 saves configuration set; 10 restores configuration defaults.
// - configuration store saves loop parameters only, never motor parameters.
// - motor store command 1 saves the whole motor parameter set.
module pulse_command_input_gear #(
   parameter MS_CYCLES = `RATE_WINDOW_NS / `CLK_PERIOD_NS
) (
   input wire SYS_CLK_I,
   input wire RST_B_I,
   input wire PULSE_A_SE_I,
   input wire PULSE_B_SE_I,
   input wire PULSE_A_DIFF_I,
   input wire PULSE_B_DIFF_I,
   input wire [15:0] REG_ADDR_I,
   input wire REG_WR_I,
   input wire REG_RD_I,
   input wire [31:0] REG_WDATA_I,
   output reg [31:0] REG_RDATA_O,
   output reg REG_RVALID_O,
   input wire [7:0] NV_FORMAT_I,
   output reg NV_STORE_CFG_O,
   output reg NV_STORE_MOTOR_O,
   output wire [7:0] NV_CFG_FORMAT_O,
   output wire [15:0] NV_CFG_NUM_O,
   output wire [15:0] NV_CFG_DEN_O,
   output wire [15:0] NV_CFG_FILTER_O,
   output wire [7:0] ACTIVE_FORMAT_O,
   output wire [31:0] GEARED_COUNT_O
);

   localparam ST_IDLE = 2'h1;
   localparam ST_RUN = 2'h2;

   // one step of the selected pulse format: 2'b01 is forward, 2'b10 is reverse
   function [1:0] pulse_step;
      input [7:0] fmt;
      input a;
      input b;
      input pa;
      input pb;
      reg a_rise;
      reg a_chg;
      reg b_chg;
      begin
         a_rise = a & ~pa;
         a_chg = a ^ pa;
         b_chg = b ^ pb;
         pulse_step = 2'b00;
         case (fmt)
            `FMT_DOUBLE_PULSE, `FMT_DIFF_DOUBLE_PULSE: begin
               // both trains rising together cancel out
               if (a_rise && !(b & ~pb)) pulse_step = 2'b01;
               else if ((b & ~pb) && !a_rise) pulse_step = 2'b10;
            end
            `FMT_PULSE_DIR, `FMT_DIFF_PULSE_DIR: begin
               // direction low counts forward
               if (a_rise) pulse_step = b ? 2'b10 : 2'b01;
            end
            `FMT_QUADRATURE, `FMT_DIFF_QUADRATURE: begin
               // x4 decode, a leading b is forward; a double change is a skipped state and is dropped
               if (a_chg && !b_chg) pulse_step = (a ^ b) ? 2'b01 : 2'b10;
               else if (b_chg && !a_chg) pulse_step = (a ^ b) ? 2'b10 : 2'b01;
            end
            default: pulse_step = 2'b00;
         endcase
      end
   endfunction

   // magnitude of a signed 48-bit value
   function [47:0] mag48;
      input [47:0] v;
      begin
         mag48 = v[47] ? (~v + 48'h000000000001) : v;
      end
   endfunction

   reg [15:0] gear_numerator_reg;
   reg [15:0] gear_denominator_reg;
   reg [7:0] pulse_format_select_reg;
   reg [31:0] raw_pulse_count_reg;
   reg [31:0] geared_pulse_count_reg;
   reg [15:0] pulse_filter_setting_reg;
   reg [15:0] raw_pulse_rate_reg;
   reg [15:0] geared_pulse_rate_reg;
   reg [7:0] config_store_command_reg;
   reg [7:0] motor_param_store_command_reg;
   reg [7:0] active_format_reg;
   reg boot_done_reg;
   reg [2:0] sync_a_reg;
   reg [2:0] sync_b_reg;
   reg [1:0] filt_reg;
   reg [1:0] filt_prev_reg;
   reg [15:0] filt_cnt_reg [0:1];
   reg [31:0] gear_base_reg;
   reg [31:0] gear_offset_reg;
   reg [1:0] div_state_reg;
   reg [47:0] div_quot_reg;
   reg [16:0] div_rem_reg;
   reg [5:0] div_bit_reg;
   reg div_neg_reg;
   reg [31:0] ms_cnt_reg;
   reg [31:0] raw_snap_reg;
   reg [31:0] geared_snap_reg;

   wire wr_raw = REG_WR_I && (REG_ADDR_I == `OFS_RAW_PULSE_COUNT);
   wire wr_geared = REG_WR_I && (REG_ADDR_I == `OFS_GEARED_PULSE_COUNT);
   wire wr_cfg_cmd = REG_WR_I && (REG_ADDR_I == `OFS_CONFIG_STORE_COMMAND);
   wire wr_motor_cmd = REG_WR_I && (REG_ADDR_I == `OFS_MOTOR_PARAM_STORE_COMMAND);
   wire cfg_init = wr_cfg_cmd && (REG_WDATA_I[7:0] == `CMD_INIT_ALL);

   wire diff_sel = (active_format_reg == `FMT_DIFF_DOUBLE_PULSE) || (active_format_reg == `FMT_DIFF_PULSE_DIR) ||
                   (active_format_reg == `FMT_DIFF_QUADRATURE);
   wire [1:0] agreed;
   wire [1:0] step;
   wire [31:0] step_ext;
   wire [31:0] raw_rel;
   wire [47:0] product;
   wire [47:0] quot_signed;
   wire window_end;
   integer ch;

   // the store image always mirrors the live configuration set, motor data never travels here
   assign NV_CFG_FORMAT_O = pulse_format_select_reg;
   assign NV_CFG_NUM_O = gear_numerator_reg;
   assign NV_CFG_DEN_O = gear_denominator_reg;
   assign NV_CFG_FILTER_O = pulse_filter_setting_reg;
   assign ACTIVE_FORMAT_O = active_format_reg;
   assign GEARED_COUNT_O = geared_pulse_count_reg;

   // three-stage synchronisers; only the first stage is kept away from any logic
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         sync_a_reg <= 3'h0;
         sync_b_reg <= 3'h0;
      end else begin
         sync_a_reg <= {sync_a_reg[1:0], diff_sel ? PULSE_A_DIFF_I : PULSE_A_SE_I};
         sync_b_reg <= {sync_b_reg[1:0], diff_sel ? PULSE_B_DIFF_I : PULSE_B_SE_I};
      end
   end

   // a level counts once stages two and three agree
   assign agreed[0] = (sync_a_reg[1] == sync_a_reg[2]) ? sync_a_reg[2] : filt_reg[0];
   assign agreed[1] = (sync_b_reg[1] == sync_b_reg[2]) ? sync_b_reg[2] : filt_reg[1];

   // glitch filter: a new level must hold for more than the filter setting in cycles
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         filt_reg <= 2'h0;
         filt_prev_reg <= 2'h0;
         filt_cnt_reg[0] <= 16'h0000;
         filt_cnt_reg[1] <= 16'h0000;
      end else begin
         filt_prev_reg <= filt_reg;
         for (ch = 0; ch < 2; ch = ch + 1) begin
            if (agreed[ch] == filt_reg[ch]) begin
               filt_cnt_reg[ch] <= 16'h0000;
            end else if (filt_cnt_reg[ch] >= pulse_filter_setting_reg) begin
               filt_reg[ch] <= agreed[ch];
               filt_cnt_reg[ch] <= 16'h0000;
            end else begin
               filt_cnt_reg[ch] <= filt_cnt_reg[ch] + 16'h0001;
            end
         end
      end
   end

   assign step = pulse_step(active_format_reg, filt_reg[0], filt_reg[1], filt_prev_reg[0], filt_prev_reg[1]);
   assign step_ext = step[1] ? 32'hffffffff : {31'h0, step[0]};

   // the decoding format is caught once after reset from the stored set, so a new select waits for a restart
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         active_format_reg <= `RST_PULSE_FORMAT_SELECT;
         boot_done_reg <= 1'b0;
      end else if (!boot_done_reg) begin
         active_format_reg <= NV_FORMAT_I;
         boot_done_reg <= 1'b1;
      end
   end

   // configuration registers and storage commands
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         gear_numerator_reg <= `RST_GEAR_NUMERATOR;
         gear_denominator_reg <= `RST_GEAR_DENOMINATOR;
         pulse_format_select_reg <= `RST_PULSE_FORMAT_SELECT;
         pulse_filter_setting_reg <= `RST_PULSE_FILTER_SETTING;
         config_store_command_reg <= 8'h00;
         motor_param_store_command_reg <= 8'h00;
         NV_STORE_CFG_O <= 1'b0;
         NV_STORE_MOTOR_O <= 1'b0;
      end else begin
         NV_STORE_CFG_O <= wr_cfg_cmd && (REG_WDATA_I[7:0] == `CMD_STORE_ALL);
         NV_STORE_MOTOR_O <= wr_motor_cmd && (REG_WDATA_I[7:0] == `CMD_STORE_ALL);
         if (wr_cfg_cmd) config_store_command_reg <= REG_WDATA_I[7:0];
         if (wr_motor_cmd) motor_param_store_command_reg <= REG_WDATA_I[7:0];
         if (cfg_init) begin
            // restore every configuration parameter to its initial value
            gear_numerator_reg <= `RST_GEAR_NUMERATOR;
            gear_denominator_reg <= `RST_GEAR_DENOMINATOR;
            pulse_format_select_reg <= `RST_PULSE_FORMAT_SELECT;
            pulse_filter_setting_reg <= `RST_PULSE_FILTER_SETTING;
         end else if (REG_WR_I) begin
            case (REG_ADDR_I)
               `OFS_GEAR_NUMERATOR: gear_numerator_reg <= REG_WDATA_I[15:0];
               `OFS_GEAR_DENOMINATOR: gear_denominator_reg <= REG_WDATA_I[15:0];
               `OFS_PULSE_FORMAT_SELECT: pulse_format_select_reg <= REG_WDATA_I[7:0];
               `OFS_PULSE_FILTER_SETTING: pulse_filter_setting_reg <= REG_WDATA_I[15:0];
               default: ;
            endcase
         end
      end
   end

   // raw count: a host write wins over a pulse in the same cycle
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         raw_pulse_count_reg <= 32'h00000000;
      end else if (wr_raw) begin
         raw_pulse_count_reg <= REG_WDATA_I;
      end else begin
         raw_pulse_count_reg <= raw_pulse_count_reg + step_ext;
      end
   end

   assign raw_rel = raw_pulse_count_reg - gear_base_reg;
   assign product = $signed(raw_rel) * $signed(gear_numerator_reg);
   assign quot_signed = div_neg_reg ? (~div_quot_reg + 48'h000000000001) : div_quot_reg;

   // geared count: offset plus (raw - base) * num / den, by a 48-step restoring divider;
   // a write to either count re-bases so the other count is not disturbed
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         gear_base_reg <= 32'h00000000;
         gear_offset_reg <= 32'h00000000;
         geared_pulse_count_reg <= 32'h00000000;
         div_state_reg <= ST_IDLE;
         div_quot_reg <= 48'h000000000000;
         div_rem_reg <= 17'h00000;
         div_bit_reg <= 6'h00;
         div_neg_reg <= 1'b0;
      end else if (wr_geared || wr_raw) begin
         // an in-flight result is stale after a re-base, so drop it
         gear_base_reg <= wr_raw ? REG_WDATA_I : raw_pulse_count_reg;
         gear_offset_reg <= wr_geared ? REG_WDATA_I : geared_pulse_count_reg;
         if (wr_geared) geared_pulse_count_reg <= REG_WDATA_I;
         div_state_reg <= ST_IDLE;
         // clear the step count too, or a finished quotient of the old base lands on the new offset
         div_bit_reg <= 6'h00;
      end else begin
         case (div_state_reg)
            ST_IDLE: begin
               // a zero denominator holds the last geared value
               if (gear_denominator_reg != 16'h0000) begin
                  div_neg_reg <= product[47];
                  div_quot_reg <= mag48(product);
                  div_rem_reg <= 17'h00000;
                  div_bit_reg <= 6'h00;
                  div_state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               if ({div_rem_reg[15:0], div_quot_reg[47]} >= {1'b0, gear_denominator_reg}) begin
                  div_rem_reg <= {div_rem_reg[15:0], div_quot_reg[47]} - {1'b0, gear_denominator_reg};
                  div_quot_reg <= {div_quot_reg[46:0], 1'b1};
               end else begin
                  div_rem_reg <= {div_rem_reg[15:0], div_quot_reg[47]};
                  div_quot_reg <= {div_quot_reg[46:0], 1'b0};
               end
               div_bit_reg <= div_bit_reg + 6'h01;
               if (div_bit_reg == 6'h2f) div_state_reg <= ST_IDLE;
            end
            default: div_state_reg <= ST_IDLE;
         endcase
         // the quotient is complete one edge after the last step
         if (div_state_reg == ST_IDLE && div_bit_reg == 6'h30) begin
            geared_pulse_count_reg <= gear_offset_reg + quot_signed[31:0];
         end
         if (div_state_reg == ST_RUN && div_bit_reg == 6'h2f) div_bit_reg <= 6'h30;
      end
   end

   assign window_end = (ms_cnt_reg == MS_CYCLES - 1);

   // pulse rates over one-millisecond windows; a count write inside a window distorts that window only
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ms_cnt_reg <= 32'h00000000;
         raw_snap_reg <= 32'h00000000;
         geared_snap_reg <= 32'h00000000;
         raw_pulse_rate_reg <= 16'h0000;
         geared_pulse_rate_reg <= 16'h0000;
      end else if (window_end) begin
         ms_cnt_reg <= 32'h00000000;
         raw_snap_reg <= raw_pulse_count_reg;
         geared_snap_reg <= geared_pulse_count_reg;
         raw_pulse_rate_reg <= raw_pulse_count_reg[15:0] - raw_snap_reg[15:0];
         geared_pulse_rate_reg <= geared_pulse_count_reg[15:0] - geared_snap_reg[15:0];
      end else begin
         ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
      end
   end

   // register read port: data one edge after the strobe, unmapped addresses read zero
   always @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         REG_RDATA_O <= 32'h00000000;
         REG_RVALID_O <= 1'b0;
      end else begin
         REG_RVALID_O <= REG_RD_I;
         if (REG_RD_I) begin
            case (REG_ADDR_I)
               `OFS_GEAR_NUMERATOR: REG_RDATA_O <= {16'h0000, gear_numerator_reg};
               `OFS_GEAR_DENOMINATOR: REG_RDATA_O <= {16'h0000, gear_denominator_reg};
               `OFS_PULSE_FORMAT_SELECT: REG_RDATA_O <= {24'h000000, pulse_format_select_reg};
               `OFS_RAW_PULSE_COUNT: REG_RDATA_O <= raw_pulse_count_reg;
               `OFS_GEARED_PULSE_COUNT: REG_RDATA_O <= geared_pulse_count_reg;
               `OFS_PULSE_FILTER_SETTING: REG_RDATA_O <= {16'h0000, pulse_filter_setting_reg};
               `OFS_RAW_PULSE_RATE: REG_RDATA_O <= {16'h0000, raw_pulse_rate_reg};
               `OFS_GEARED_PULSE_RATE: REG_RDATA_O <= {16'h0000, geared_pulse_rate_reg};
               `OFS_CONFIG_STORE_COMMAND: REG_RDATA_O <= {24'h000000, config_store_command_reg};
               `OFS_MOTOR_PARAM_STORE_COMMAND: REG_RDATA_O <= {24'h000000, motor_param_store_command_reg};
               default: REG_RDATA_O <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // pulse_command_input_gear

// ==== tb/pulse_gen_model.sv ====
`timescale 1ns/1ns
// stands in for the motion controller: one command step per request on step_i
module pulse_gen_model #(
   parameter int W = 12
) (
   input wire clk_i,
   input wire step_i,
   input wire dir_i,
   input wire [1:0] mode_i,
   output reg a_o = 1'b0,
   output reg b_o = 1'b0,
   output reg busy_o = 1'b0
);
   reg [1:0] ph = 2'h0;
   // behavioural sequencer; each level is held W cycles so the input filter passes it
   always @(posedge clk_i) if (step_i) begin
      #1 busy_o = 1'b1;
      case (mode_i)
         2'h0: if (dir_i) b_o = 1'b1; else a_o = 1'b1;
         2'h1: begin
            b_o = dir_i; // direction settles before the pulse edge
            repeat (W) @(posedge clk_i);
            #1 a_o = 1'b1;
         end
         default: begin
            ph = dir_i ? ph - 2'h1 : ph + 2'h1;
            a_o = ph[1] ^ ph[0]; // a leads b when moving forward
            b_o = ph[1];
         end
      endcase
      repeat (W) @(posedge clk_i);
      #1 a_o = mode_i[1] ? a_o : 1'b0;
      b_o = (mode_i == 2'h0) ? 1'b0 : b_o;
      repeat (W) @(posedge clk_i);
      #1 busy_o = 1'b0;
   end
endmodule // pulse_gen_model

// ==== tb/pulse_command_input_gear_checker.sv ====
`timescale 1ns/1ns
`include "pulse_gear_consts.vh"
module pulse_command_input_gear_checker #(
   parameter MS_CYCLES = 100
) (
   input wire SYS_CLK_I, RST_B_I, PULSE_A_SE_I, PULSE_B_SE_I, PULSE_A_DIFF_I, PULSE_B_DIFF_I,
   input wire REG_WR_I, REG_RD_I, REG_RVALID_O, NV_STORE_CFG_O, NV_STORE_MOTOR_O,
   input wire [15:0] REG_ADDR_I, NV_CFG_NUM_O, NV_CFG_DEN_O, NV_CFG_FILTER_O,
   input wire [31:0] REG_WDATA_I, REG_RDATA_O, GEARED_COUNT_O,
   input wire [7:0] NV_FORMAT_I, NV_CFG_FORMAT_O, ACTIVE_FORMAT_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);
   // decoded write strobes; narrow registers only look at the low bits
   wire [15:0] wd_lo = REG_WDATA_I[15:0];
   wire wr_cfg = REG_WR_I && REG_ADDR_I == `OFS_CONFIG_STORE_COMMAND;
   wire wr_mot = REG_WR_I && REG_ADDR_I == `OFS_MOTOR_PARAM_STORE_COMMAND;
   wire mapped = REG_ADDR_I inside {`OFS_GEAR_NUMERATOR, `OFS_GEAR_DENOMINATOR, `OFS_PULSE_FORMAT_SELECT,
      `OFS_RAW_PULSE_COUNT, `OFS_GEARED_PULSE_COUNT, `OFS_PULSE_FILTER_SETTING, `OFS_RAW_PULSE_RATE,
      `OFS_GEARED_PULSE_RATE, `OFS_CONFIG_STORE_COMMAND, `OFS_MOTOR_PARAM_STORE_COMMAND};
   sequence one_pulse(s);
      s ##1 !s;
   endsequence
   a_rvalid_follows: assert property (REG_RVALID_O == $past(REG_RD_I))
      else $error("read valid not one cycle after read strobe");
   a_unmapped_zero: assert property (REG_RD_I && !mapped |=> REG_RDATA_O == 32'h0)
      else $error("unmapped read not zero");
   a_cfg_store_pulse: assert property (wr_cfg && wd_lo[7:0] == `CMD_STORE_ALL |=> one_pulse(NV_STORE_CFG_O))
      else $error("config store pulse missing");
   a_cfg_store_cause: assert property (NV_STORE_CFG_O |-> $past(wr_cfg && wd_lo[7:0] == `CMD_STORE_ALL))
      else $error("config store pulse without command");
   a_motor_kept_out: assert property (wr_cfg |=> !NV_STORE_MOTOR_O)
      else $error("config store touched motor set");
   a_motor_store_pulse: assert property (wr_mot && wd_lo[7:0] == 8'h01 |=> one_pulse(NV_STORE_MOTOR_O))
      else $error("motor store pulse missing");
   a_init_defaults: assert property (wr_cfg && wd_lo[7:0] == `CMD_INIT_ALL |=>
      NV_CFG_NUM_O == `RST_GEAR_NUMERATOR && NV_CFG_DEN_O == `RST_GEAR_DENOMINATOR &&
      NV_CFG_FILTER_O == `RST_PULSE_FILTER_SETTING && NV_CFG_FORMAT_O == `RST_PULSE_FORMAT_SELECT)
      else $error("initialise did not restore defaults");
   a_format_held: assert property ($past(RST_B_I, 2) |-> $stable(ACTIVE_FORMAT_O))
      else $error("active format changed without restart");
   a_format_loaded: assert property ($rose(RST_B_I) |=> ACTIVE_FORMAT_O == $past(NV_FORMAT_I))
      else $error("stored format not taken at restart");
   a_geared_readback: assert property (REG_RD_I && REG_ADDR_I == `OFS_GEARED_PULSE_COUNT |=>
      REG_RDATA_O == $past(GEARED_COUNT_O)) else $error("geared count read mismatch");
   a_num_image: assert property (REG_WR_I && REG_ADDR_I == `OFS_GEAR_NUMERATOR |=>
      NV_CFG_NUM_O == $past(wd_lo)) else $error("numerator image not updated");
endmodule // pulse_command_input_gear_checker

bind pulse_command_input_gear pulse_command_input_gear_checker #(.MS_CYCLES(MS_CYCLES)) checker_i (
   .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .PULSE_A_SE_I(PULSE_A_SE_I), .PULSE_B_SE_I(PULSE_B_SE_I),
   .PULSE_A_DIFF_I(PULSE_A_DIFF_I), .PULSE_B_DIFF_I(PULSE_B_DIFF_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
   .REG_RVALID_O(REG_RVALID_O), .NV_STORE_CFG_O(NV_STORE_CFG_O), .NV_STORE_MOTOR_O(NV_STORE_MOTOR_O),
   .REG_ADDR_I(REG_ADDR_I), .NV_CFG_NUM_O(NV_CFG_NUM_O), .NV_CFG_DEN_O(NV_CFG_DEN_O),
   .NV_CFG_FILTER_O(NV_CFG_FILTER_O), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
   .GEARED_COUNT_O(GEARED_COUNT_O), .NV_FORMAT_I(NV_FORMAT_I), .NV_CFG_FORMAT_O(NV_CFG_FORMAT_O),
   .ACTIVE_FORMAT_O(ACTIVE_FORMAT_O));

// ==== tb/pulse_command_input_gear_bench.sv ====
`timescale 1ns/1ns
`include "pulse_gear_consts.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module pulse_command_input_gear_bench;
   localparam int W = 12; // pulse level width, above filter plus sync
   reg clk = 0, rst_b = 0, wr = 0, rd = 0, step = 0, dir = 0;
   reg [15:0] addr = 16'h0000, den;
   reg signed [15:0] num;
   reg [31:0] wdata = 32'h0, e_rd, exp_q[$];
   reg [7:0] nv_fmt = 8'h01;
   reg [1:0] mode = 2'h1;
   wire ma, mb, busy, rvalid, st_cfg, st_mot;
   wire [31:0] rdata, geared;
   wire [7:0] cfg_fmt, act_fmt;
   wire [15:0] cfg_num, cfg_den, cfg_flt;
   wire diff = nv_fmt >= 8'h0a;
   int n_fail = 0, comparisons = 0, seed = 70, k, f, ge, raw_e;
   reg [7:0] fmts [7] = '{8'h00, 8'h01, 8'h02, 8'h0a, 8'h0b, 8'h0c, 8'h05};
   reg [15:0] ofs [11] = '{`OFS_GEAR_NUMERATOR, `OFS_GEAR_DENOMINATOR, `OFS_PULSE_FORMAT_SELECT,
      `OFS_RAW_PULSE_COUNT, `OFS_GEARED_PULSE_COUNT, `OFS_PULSE_FILTER_SETTING, `OFS_RAW_PULSE_RATE,
      `OFS_GEARED_PULSE_RATE, `OFS_CONFIG_STORE_COMMAND, `OFS_MOTOR_PARAM_STORE_COMMAND, 16'h1970};
   reg [31:0] rstv [11] = '{`RST_GEAR_NUMERATOR, `RST_GEAR_DENOMINATOR, `RST_PULSE_FORMAT_SELECT, 0, 0,
      `RST_PULSE_FILTER_SETTING, 0, 0, 0, 0, 0};
   initial forever #4 clk = ~clk;
   pulse_gen_model #(.W(W)) pulse_gen_model_i (.clk_i(clk), .step_i(step), .dir_i(dir), .mode_i(mode),
      .a_o(ma), .b_o(mb), .busy_o(busy));
   // the idle pin pair carries the swapped stream, so reading the wrong pair miscounts
   pulse_command_input_gear #(.MS_CYCLES(100)) pulse_command_input_gear_i (.SYS_CLK_I(clk), .RST_B_I(rst_b),
      .PULSE_A_SE_I(diff ? mb : ma), .PULSE_B_SE_I(diff ? ma : mb), .PULSE_A_DIFF_I(diff ? ma : mb),
      .PULSE_B_DIFF_I(diff ? mb : ma), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
      .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .NV_FORMAT_I(nv_fmt), .NV_STORE_CFG_O(st_cfg),
      .NV_STORE_MOTOR_O(st_mot), .NV_CFG_FORMAT_O(cfg_fmt), .NV_CFG_NUM_O(cfg_num), .NV_CFG_DEN_O(cfg_den),
      .NV_CFG_FILTER_O(cfg_flt), .ACTIVE_FORMAT_O(act_fmt), .GEARED_COUNT_O(geared));
   task automatic wr_reg(input [15:0] a, input [31:0] d);
      @(posedge clk); #1 wr = 1; addr = a; wdata = d;
      @(posedge clk); #1 wr = 0;
   endtask
   // the expected read value is noted now and compared when read valid shows
   task automatic rd_reg(input [15:0] a, input [31:0] e);
      @(posedge clk); #1 rd = 1; addr = a; exp_q.push_back(e);
      @(posedge clk); #1 rd = 0;
   endtask
   task automatic send(input d);
      @(posedge clk); #1 step = 1; dir = d;
      @(posedge clk); #1 step = 0;
      @(posedge clk);
      for (k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clk);
      `CHK("pulse model idle", 1'b0, busy)
   endtask
   // restart is a reset with the stored format presented
   task automatic restart(input [7:0] fm);
      @(posedge clk); #1 nv_fmt = fm; rst_b = 0;
      mode = (fm >= 8'h0a) ? 2'(fm - 8'h0a) : 2'(fm);
      repeat (4) @(posedge clk); #1 rst_b = 1;
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // read monitor: oldest note against each returned word
   always @(posedge clk) if (rvalid === 1'b1) begin
      e_rd = exp_q.pop_front();
      `CHK("read data", e_rd, rdata)
   end
   initial begin
      #400000 n_fail++;
      tally_and_finish;
   end
   initial begin
      restart(8'h01);
      for (f = 0; f < 11; f++) rd_reg(ofs[f], rstv[f]);
      wr_reg(`OFS_RAW_PULSE_RATE, 32'h1234);
      wr_reg(`OFS_GEARED_PULSE_RATE, 32'h0055);
      wr_reg(16'h1970, 32'hffff);
      rd_reg(`OFS_RAW_PULSE_RATE, 0);
      rd_reg(`OFS_GEARED_PULSE_RATE, 0);
      rd_reg(16'h1970, 0);
      wr_reg(`OFS_RAW_PULSE_COUNT, 32'h8000_0005);
      rd_reg(`OFS_RAW_PULSE_COUNT, 32'h8000_0005);
      wr_reg(`OFS_GEARED_PULSE_COUNT, 32'hffff_fff0);
      `CHK("geared out", 32'hffff_fff0, geared)
      wr_reg(`OFS_MOTOR_PARAM_STORE_COMMAND, 32'h1);
      `CHK("motor store", 1'b1, st_mot)
      `CHK("config store", 1'b0, st_cfg)
      @(posedge clk); #1 `CHK("motor store end", 1'b0, st_mot)
      for (f = 0; f < 7; f++) begin
         wr_reg(`OFS_PULSE_FORMAT_SELECT, fmts[f]);
         `CHK("format before restart", nv_fmt, act_fmt)
         wr_reg(`OFS_CONFIG_STORE_COMMAND, 32'h1);
         `CHK("config store", 1'b1, st_cfg)
         `CHK("stored format", fmts[f], cfg_fmt)
         `CHK("motor store", 1'b0, st_mot)
         restart(fmts[f]);
         @(posedge clk); #1 `CHK("active format", fmts[f], act_fmt)
         rd_reg(`OFS_PULSE_FORMAT_SELECT, `RST_PULSE_FORMAT_SELECT);
         num = 16'($random(seed) % 2000);
         den = 16'h0001 + 16'($random(seed) & 32'h07ff);
         wr_reg(`OFS_GEAR_NUMERATOR, {16'h0, num});
         wr_reg(`OFS_GEAR_DENOMINATOR, {16'h0, den});
         for (int s = 0; s < 6; s++) send(s == 2);
         raw_e = (fmts[f] == 8'h05) ? 0 : 4;
         ge = (raw_e * int'(num)) / int'(den);
         for (k = 0; k < 300 && geared !== 32'(ge); k++) @(posedge clk);
         `CHK("geared count", 32'(ge), geared)
         rd_reg(`OFS_RAW_PULSE_COUNT, 32'(raw_e));
         rd_reg(`OFS_GEAR_NUMERATOR, {16'h0, num});
         rd_reg(`OFS_GEAR_DENOMINATOR, {16'h0, den});
      end
      wr_reg(`OFS_CONFIG_STORE_COMMAND, 32'h0a);
      `CHK("init numerator", `RST_GEAR_NUMERATOR, cfg_num)
      `CHK("init denominator", `RST_GEAR_DENOMINATOR, cfg_den)
      `CHK("init filter", `RST_PULSE_FILTER_SETTING, cfg_flt)
      rd_reg(`OFS_GEAR_NUMERATOR, `RST_GEAR_NUMERATOR);
      // windows close on every 100th edge after release, so each read below lands in a known window
      restart(8'h01);
      wr_reg(`OFS_RAW_PULSE_COUNT, 32'h0123);
      wr_reg(`OFS_GEARED_PULSE_COUNT, 32'h0055);
      repeat (100) @(posedge clk);
      rd_reg(`OFS_RAW_PULSE_RATE, 32'h0123);
      rd_reg(`OFS_GEARED_PULSE_RATE, 32'h0055);
      repeat (100) @(posedge clk);
      rd_reg(`OFS_RAW_PULSE_RATE, 0);
      rd_reg(`OFS_GEARED_PULSE_RATE, 0);
      repeat (3) @(posedge clk);
      tally_and_finish;
   end
endmodule // pulse_command_input_gear_bench
